// ---- hw/fdc_fmt_params.svh ----
`ifndef FDC_FMT_PARAMS_SVH
`define FDC_FMT_PARAMS_SVH
// Register port offsets.
`define ADDR_DATA 2'h0
`define ADDR_MSR 2'h1
`define ADDR_DRIVE_VIEW 2'h2
`define ADDR_STATUS_A 2'h3
// Opcodes: dump matched on all bits, format on bits 7 and 5-0.
`define OP_DUMP 8'h0E
`define OP_FORMAT_LOW 6'h0D
`define OP_DENSITY_BIT 6
// Result lengths and parameter count.
`define LEN_DUMP 4'hA
`define LEN_FORMAT 4'h7
`define LEN_INVALID 4'h1
`define FMT_PARAM_LAST 4'h5
// Field positions.
`define STATUS_A_HEAD_BIT 3
`define ST1_OVERRUN_BIT 4
// Reset values and status 0 codes.
`define RST_FIFO_DIS 1'b1
`define RST_FIFO_THRESHOLD 4'h0
`define RST_PRECOMP_TRACK 8'h00
`define RST_BYTE 8'h00
`define STATUS0_INVALID 8'h80
`define STATUS0_ABNORMAL 2'h1
`endif

// ---- hw/fdc_fmt_pkg.sv ----
package fdc_fmt_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PARAM = 3'b001,
        ST_WAIT_IDX1 = 3'b010,
        ST_FORMAT = 3'b011,
        ST_RESULT = 3'b100
    } seq_state_t;
    typedef enum logic [1:0] {
        RES_DUMP = 2'b00,
        RES_FORMAT = 2'b01,
        RES_INVALID = 2'b10
    } result_kind_t;
    typedef logic [7:0] byte_t;
endpackage : fdc_fmt_pkg

// ---- hw/fdc_register_dump_command_format_track.sv ----
`timescale 1ns/1ps
`include "fdc_fmt_params.svh"
// How it works
// - Dump bytes one to four return present track number of drives 0 to 3.
// - Dump bytes five, six return step rate, delays and DMA flag in bit 0.
// - Dump byte seven: sectors per track after format, else end-of-track sector.
// - Dump byte eight: lock flag, zero, drive mode configuration bits.
// - Dump bytes nine, ten echo controller_config_command bytes three and four.
// - Hardware reset restores all; software reset spares locked fields when locked.
// - Lock flag defaults to 0, set from lock opcode bit 7.
// - Format waits for an index pulse, then writes the whole track.
// - Format ends on the second index pulse and raises an interrupt.
// - Layout follows density bit, index field mode and group drive mode.
// - Address bytes may arrive by DMA or processor, FIFO on or off.
// - Opcode bit 6 selects FM (0) or DOUBLE_DENSITY_SELECT (1) encoding.
// - Second byte bits 1,0 select drive; 2 and 3 need permission.
// - Second byte bit 2 selects side; head select output is its inverse.
// - Drive shows in output register, head in status A, both in status 0.
// - Size code 0 to 7 gives 128 bytes doubled per step.
// - Fourth byte sets sector count; pattern byte fills every data field.
// - Fifth byte sets inter-sector gap length, sixth is the pattern.
// - Format result is status 0, 1, 2 then four undefined bytes.
module fdc_register_dump_command_format_track #(
    parameter int MAX_SIZE_CODE = 7
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic soft_reset,
    input wire logic [1:0] addr,
    input wire fdc_fmt_pkg::byte_t wdata,
    input wire logic wr,
    input wire logic rd,
    output fdc_fmt_pkg::byte_t rdata,
    input wire logic specify_load,
    input wire fdc_fmt_pkg::byte_t specify_byte1,
    input wire fdc_fmt_pkg::byte_t specify_byte2,
    input wire logic config_load,
    input wire fdc_fmt_pkg::byte_t config_byte3,
    input wire fdc_fmt_pkg::byte_t config_byte4,
    input wire logic perp_load,
    input wire logic [5:0] perp_bits,
    input wire logic lock_load,
    input wire logic lock_value,
    input wire logic track_load,
    input wire logic [1:0] track_drive,
    input wire fdc_fmt_pkg::byte_t track_value,
    input wire logic rw_done,
    input wire fdc_fmt_pkg::byte_t rw_end_sector,
    input wire logic index_address_field_mode,
    input wire logic four_drives,
    input wire logic swap_drives,
    input wire logic index_n,
    input wire logic sector_start,
    output logic dma_req,
    output logic irq,
    output logic [1:0] logical_drive_select,
    output logic head_select_output_n,
    output logic write_gate,
    output logic double_density_select,
    output logic iso_layout,
    output logic [1:0] group_layout,
    output fdc_fmt_pkg::byte_t gap3_len,
    output fdc_fmt_pkg::byte_t fill_pattern,
    output logic sector_valid,
    output fdc_fmt_pkg::byte_t id_track,
    output fdc_fmt_pkg::byte_t id_head,
    output fdc_fmt_pkg::byte_t id_sector,
    output fdc_fmt_pkg::byte_t id_size,
    output logic [14:0] data_len
);
    import fdc_fmt_pkg::*;

    // A size code above seven would overflow the data length port.
    if (MAX_SIZE_CODE < 0 || MAX_SIZE_CODE > 7)
    begin : bad_max_size_code
        $error("MAX_SIZE_CODE must lie in 0..7 to fit data_len.");
    end

    // Data field length for a size code; codes above the limit are clamped.
    function automatic logic [14:0] len_of(input byte_t code);
        logic [2:0] c;
        c = (code > byte_t'(MAX_SIZE_CODE)) ? 3'(MAX_SIZE_CODE) : code[2:0];
        return 15'h0080 << c;
    endfunction : len_of

    seq_state_t state;
    result_kind_t kind;
    byte_t present_track_number [4];
    byte_t spec1, spec2, end_of_track_sector, sectors_per_track, opcode;
    logic [5:0] drive_mode;
    logic lock, implied_seek_enable, fifo_dis, poll_dis, last_fmt;
    logic [3:0] fifo_threshold, cnt, res_len;
    byte_t precomp_start_track;
    logic [1:0] ds;
    logic head_side_select, idx_prev, overrun;
    byte_t id_buf [4];
    logic [1:0] id_cnt;
    logic id_full;
    byte_t sec_done;
    logic precomp_kept;
    byte_t precomp_prev;

    // Bus decode and phase conditions.
    wire data_wr = wr && addr == `ADDR_DATA;
    wire data_rd = rd && addr == `ADDR_DATA;
    wire idx_edge = idx_prev && !index_n;
    wire need_id = state == ST_FORMAT && !id_full && sec_done < sectors_per_track;
    wire id_wr = data_wr && need_id;
    wire host_rqm = state == ST_IDLE || state == ST_PARAM || state == ST_RESULT
        || (need_id && !spec2[0]);
    wire busy = state != ST_IDLE;
    wire is_dump = wdata == `OP_DUMP;
    wire is_fmt = !wdata[7] && wdata[5:0] == `OP_FORMAT_LOW;
    wire take_sector = state == ST_FORMAT && sector_start && id_full;
    wire miss_sector = state == ST_FORMAT && sector_start && !id_full
        && sec_done < sectors_per_track;
    // Drive 2 needs four drives or the swap, drive 3 needs four drives.
    wire ds_ok = wdata[1:0] == 2'h3 ? four_drives
        : wdata[1:0] == 2'h2 ? (four_drives || swap_drives) : 1'b1;
    wire [1:0] next_ds = ds_ok ? wdata[1:0] : 2'h0;
    wire byte_t result_status_zero = {overrun ? `STATUS0_ABNORMAL : 2'h0, 3'h0,
        head_side_select, ds};

    // Result byte for the current kind and index.
    function automatic byte_t result_byte(input result_kind_t k, input logic [3:0] i);
        byte_t b;
        b = `RST_BYTE;
        if (k == RES_INVALID)
        begin
            b = `STATUS0_INVALID;
        end
        else if (k == RES_FORMAT)
        begin
            case (i)
                4'h0: b = result_status_zero;
                4'h1: b = byte_t'(overrun) << `ST1_OVERRUN_BIT;
                default: b = `RST_BYTE;
            endcase
        end
        else
        begin
            case (i)
                4'h0, 4'h1, 4'h2, 4'h3: b = present_track_number[i[1:0]];
                4'h4: b = spec1;
                4'h5: b = spec2;
                4'h6: b = last_fmt ? sectors_per_track : end_of_track_sector;
                4'h7: b = {lock, 1'b0, drive_mode};
                4'h8: b = {1'b0, implied_seek_enable, fifo_dis, poll_dis, fifo_threshold};
                4'h9: b = precomp_start_track;
                default: b = `RST_BYTE;
            endcase
        end
        return b;
    endfunction : result_byte

    // Read data stands only in the cycle after the strobe.
    wire byte_t next_rdata = !rd ? `RST_BYTE
        : addr == `ADDR_DATA ? (state == ST_RESULT ? result_byte(kind, cnt) : `RST_BYTE)
        : addr == `ADDR_MSR ? {host_rqm, state == ST_RESULT, state == ST_FORMAT && !spec2[0],
            busy, 4'h0}
        : addr == `ADDR_DRIVE_VIEW ? {6'h0, ds}
        : byte_t'(head_side_select) << `STATUS_A_HEAD_BIT;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            rdata <= `RST_BYTE;
        else
            rdata <= next_rdata;
    end

    // Stored parameters; the software reset spares the locked ones.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            present_track_number <= '{default: `RST_BYTE};
            spec1 <= `RST_BYTE;
            spec2 <= `RST_BYTE;
            end_of_track_sector <= `RST_BYTE;
            drive_mode <= 6'h0;
            implied_seek_enable <= 1'b0;
            poll_dis <= 1'b0;
            fifo_dis <= `RST_FIFO_DIS;
            fifo_threshold <= `RST_FIFO_THRESHOLD;
            precomp_start_track <= `RST_PRECOMP_TRACK;
            lock <= 1'b0;
        end
        else if (soft_reset)
        begin
            present_track_number <= '{default: `RST_BYTE};
            spec1 <= `RST_BYTE;
            spec2 <= `RST_BYTE;
            end_of_track_sector <= `RST_BYTE;
            drive_mode <= 6'h0;
            implied_seek_enable <= 1'b0;
            poll_dis <= 1'b0;
            if (!lock)
            begin
                fifo_dis <= `RST_FIFO_DIS;
                fifo_threshold <= `RST_FIFO_THRESHOLD;
                precomp_start_track <= `RST_PRECOMP_TRACK;
            end
        end
        else
        begin
            if (track_load)
                present_track_number[track_drive] <= track_value;
            if (specify_load)
            begin
                spec1 <= specify_byte1;
                spec2 <= specify_byte2;
            end
            if (rw_done)
                end_of_track_sector <= rw_end_sector;
            if (perp_load)
                drive_mode <= perp_bits;
            if (config_load)
            begin
                {implied_seek_enable, fifo_dis, poll_dis, fifo_threshold} <= config_byte3[6:0];
                precomp_start_track <= config_byte4;
            end
            if (lock_load)
                lock <= lock_value;
        end
    end

    // Command sequencer: opcode, parameters, index wait, track write, result.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= ST_IDLE;
            kind <= RES_INVALID;
            cnt <= 4'h0;
            res_len <= 4'h0;
            opcode <= `RST_BYTE;
            ds <= 2'h0;
            head_side_select <= 1'b0;
            sectors_per_track <= `RST_BYTE;
            gap3_len <= `RST_BYTE;
            fill_pattern <= `RST_BYTE;
            id_size <= `RST_BYTE;
            last_fmt <= 1'b0;
            overrun <= 1'b0;
            irq <= 1'b0;
        end
        else if (soft_reset)
        begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            sectors_per_track <= `RST_BYTE;
            last_fmt <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            if (rw_done)
                last_fmt <= 1'b0;
            case (state)
                ST_IDLE:
                    if (data_wr)
                    begin
                        opcode <= wdata;
                        overrun <= 1'b0;
                        cnt <= 4'h0;
                        if (is_dump)
                        begin
                            kind <= RES_DUMP;
                            res_len <= `LEN_DUMP;
                            state <= ST_RESULT;
                        end
                        else if (is_fmt)
                            state <= ST_PARAM;
                        else
                        begin
                            kind <= RES_INVALID;
                            res_len <= `LEN_INVALID;
                            state <= ST_RESULT;
                        end
                    end
                ST_PARAM:
                    if (data_wr)
                    begin
                        cnt <= cnt + 4'h1;
                        case (cnt)
                            4'h0:
                            begin
                                ds <= next_ds;
                                head_side_select <= wdata[2];
                            end
                            4'h1: id_size <= wdata;
                            4'h2: sectors_per_track <= wdata;
                            4'h3: gap3_len <= wdata;
                            default: fill_pattern <= wdata;
                        endcase
                        if (cnt == `FMT_PARAM_LAST - 4'h1)
                            state <= ST_WAIT_IDX1;
                    end
                ST_WAIT_IDX1:
                    if (idx_edge)
                        state <= ST_FORMAT;
                ST_FORMAT:
                    if (miss_sector || idx_edge)
                    begin
                        overrun <= miss_sector;
                        irq <= 1'b1;
                        last_fmt <= 1'b1;
                        kind <= RES_FORMAT;
                        res_len <= `LEN_FORMAT;
                        cnt <= 4'h0;
                        state <= ST_RESULT;
                    end
                ST_RESULT:
                    if (data_rd)
                    begin
                        irq <= 1'b0;
                        cnt <= cnt + 4'h1;
                        if (cnt == res_len - 4'h1)
                            state <= ST_IDLE;
                    end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Address bytes gather in order; a full set is handed to the encoder per sector.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            id_buf <= '{default: `RST_BYTE};
            id_cnt <= 2'h0;
            id_full <= 1'b0;
            sec_done <= `RST_BYTE;
            idx_prev <= 1'b1;
            sector_valid <= 1'b0;
            id_track <= `RST_BYTE;
            id_head <= `RST_BYTE;
            id_sector <= `RST_BYTE;
            data_len <= 15'h0080;
        end
        else
        begin
            idx_prev <= index_n;
            sector_valid <= take_sector;
            if (state != ST_FORMAT)
            begin
                id_cnt <= 2'h0;
                id_full <= 1'b0;
                sec_done <= `RST_BYTE;
                data_len <= len_of(id_size);
            end
            else if (take_sector)
            begin
                {id_track, id_head, id_sector} <= {id_buf[0], id_buf[1], id_buf[2]};
                data_len <= len_of(id_buf[3]);
                id_full <= 1'b0;
                sec_done <= sec_done + 8'h01;
            end
            else if (id_wr)
            begin
                id_buf[id_cnt] <= wdata;
                id_cnt <= id_cnt + 2'h1;
                id_full <= id_cnt == 2'h3;
            end
        end
    end

    // Drive side outputs; the head select pin is active low.
    assign logical_drive_select = ds;
    assign head_select_output_n = !head_side_select;
    assign write_gate = state == ST_FORMAT && !miss_sector;
    assign double_density_select = opcode[`OP_DENSITY_BIT];
    assign iso_layout = index_address_field_mode;
    assign group_layout = drive_mode[1:0];
    assign dma_req = need_id && spec2[0];

    fmt_start_a: assert property (@(posedge mclk) disable iff (!reset_n || soft_reset)
        state == ST_WAIT_IDX1 && idx_edge |=> state == ST_FORMAT && write_gate)
        else $error("Format did not begin at the first index pulse.");
    fmt_end_a: assert property (@(posedge mclk) disable iff (!reset_n || soft_reset)
        state == ST_FORMAT && idx_edge && !miss_sector |=> state == ST_RESULT && irq && !overrun)
        else $error("Second index pulse did not end the format with an interrupt.");
    dump_len_a: assert property (@(posedge mclk) disable iff (!reset_n || soft_reset)
        state == ST_IDLE && data_wr && is_dump |=> state == ST_RESULT && res_len == 4'hA)
        else $error("Dump opcode did not open a ten byte result.");
    lock_keep_a: assert property (@(posedge mclk) disable iff (!reset_n)
        soft_reset && lock |=> fifo_dis == $past(fifo_dis) && precomp_kept)
        else $error("Locked field changed on a software reset.");
    lock_clear_a: assert property (@(posedge mclk) disable iff (!reset_n)
        soft_reset && !lock |=> fifo_dis && fifo_threshold == 4'h0 && !implied_seek_enable)
        else $error("Unlocked software reset left a field unchanged.");
    overrun_a: assert property (@(posedge mclk) disable iff (!reset_n || soft_reset)
        miss_sector |=> state == ST_RESULT && overrun ##0 result_byte(RES_FORMAT, 4'h1) == 8'h10)
        else $error("Missing address bytes did not report overrun.");
    eot_sel_a: assert property (@(posedge mclk) disable iff (!reset_n || soft_reset)
        rw_done && state != ST_FORMAT |=> result_byte(RES_DUMP, 4'h6) == end_of_track_sector)
        else $error("Dump byte seven ignored a later read or write.");
    head_pin_a: assert property (@(posedge mclk) disable iff (!reset_n)
        head_select_output_n != result_status_zero[2])
        else $error("Head select pin does not mirror the chosen side.");

    // Helper for the lock check: precompensation track unchanged.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            precomp_prev <= `RST_PRECOMP_TRACK;
        else
            precomp_prev <= precomp_start_track;
    end
    assign precomp_kept = precomp_prev == precomp_start_track;
endmodule : fdc_register_dump_command_format_track

// ---- dv/fdc_drive_model.sv ----
`timescale 1ns/1ps
// Drive and encoder stand-in: it makes index pulses and sector requests on command.
module fdc_drive_model (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic idx_req,
    input wire logic sec_req,
    output logic index_n,
    output logic sector_start
);
    logic [1:0] low_cnt;

    // The index line idles high and stays low three cycles, so a slow sampler still sees it.
    always_ff @(posedge mclk or negedge reset_n)
        if (!reset_n)
            {low_cnt, sector_start} <= 3'h0;
        else
            {low_cnt, sector_start} <= {idx_req ? 2'h3 : low_cnt - {1'b0, low_cnt != 2'h0}, sec_req};

    assign index_n = (low_cnt == 2'h0);
endmodule : fdc_drive_model

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
// Self-checking bench for the register dump and track format sequencer.
module tb_top;
    import fdc_fmt_pkg::*;
    logic mclk, reset_n, soft_reset, wr, rd, specify_load, config_load, perp_load, lock_load;
    logic track_load, rw_done, index_address_field_mode, four_drives, swap_drives, index_n;
    logic sector_start, dma_req, irq, head_select_output_n, write_gate, double_density_select;
    logic iso_layout, sector_valid, lock_value, idx_req, sec_req, rd_q, lk;
    logic [1:0] addr, track_drive, logical_drive_select, group_layout;
    logic [5:0] perp_bits, pp;
    logic [14:0] data_len;
    logic [15:0] e;
    logic [38:0] s;
    logic [31:0] r;
    byte_t wdata, rdata, specify_byte1, specify_byte2, config_byte3, config_byte4, track_value;
    byte_t rw_end_sector, gap3_len, fill_pattern, id_track, id_head, id_sector, id_size;
    byte_t sp1, sp2, c3, c4, b7;
    byte_t trk[4];
    logic [15:0] rq[$];
    logic [38:0] sq[$];
    int fail_count, comparisons;

    fdc_register_dump_command_format_track #(.MAX_SIZE_CODE(7)) dut_u (
        .mclk, .reset_n, .soft_reset, .addr, .wdata, .wr, .rd, .rdata, .specify_load,
        .specify_byte1, .specify_byte2, .config_load, .config_byte3, .config_byte4, .perp_load,
        .perp_bits, .lock_load, .lock_value, .track_load, .track_drive, .track_value, .rw_done,
        .rw_end_sector, .index_address_field_mode, .four_drives, .swap_drives, .index_n,
        .sector_start,
        .dma_req, .irq, .logical_drive_select, .head_select_output_n, .write_gate,
        .double_density_select, .iso_layout, .group_layout, .gap3_len, .fill_pattern,
        .sector_valid, .id_track, .id_head, .id_sector, .id_size, .data_len
    );
    fdc_drive_model drive_u (.mclk, .reset_n, .idx_req, .sec_req, .index_n, .sector_start);

    // Free-running controller clock.
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task miss(input string m);
        fail_count++;
        $display("MISMATCH at %0t: %s", $time, m);
    endtask : miss

    task chk(input logic [39:0] g, input logic [39:0] x, input string m);
        comparisons++;
        if (g !== x)
            miss(m);
    endtask : chk

    task end_sim;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim

    // Bus cycles last one clock each; a read notes its expected byte and mask first.
    task wb(input byte_t d);
        @(posedge mclk);
        addr <= 2'h0;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wb

    task rb(input logic [1:0] a, input byte_t x, input byte_t m);
        rq.push_back({m, x & m});
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
    endtask : rb

    task pulse(input logic ix);
        @(posedge mclk);
        idx_req <= ix;
        sec_req <= !ix;
        @(posedge mclk);
        {idx_req, sec_req} <= 2'b00;
    endtask : pulse

    task wait_hi(input logic ir);
        for (int k = 0; k < 12 && (ir ? irq : write_gate) !== 1'b1; k++)
            @(negedge mclk);
    endtask : wait_hi

    // The model mirrors which stored fields a software reset spares while the lock is set.
    task srst;
        @(posedge mclk);
        soft_reset <= 1'b1;
        @(posedge mclk);
        soft_reset <= 1'b0;
        trk = '{default: 8'h00};
        {sp1, sp2, b7, pp} = 30'h0;
        c3 = {2'b00, lk ? c3[5] : 1'b1, 1'b0, lk ? c3[3:0] : 4'h0};
        c4 = lk ? c4 : 8'h00;
    endtask : srst

    task dump;
        byte_t x[10];
        x = '{trk[0], trk[1], trk[2], trk[3], sp1, sp2, b7, {lk, 1'b0, pp}, {1'b0, c3[6:0]}, c4};
        wb(8'h0E);
        for (int k = 0; k < 10; k++)
            rb(2'h0, x[k], 8'hFF);
    endtask : dump

    // One format: drive code from i, size code i, two sectors, or an overrun when ovr is set.
    task fmt(input int i, input logic ovr);
        logic [1:0] de;
        logic [31:0] t;
        byte_t s0;
        r = $urandom;
        de = ((i[1:0] == 2'h2 && !(r[2] | r[1])) || (i[1:0] == 2'h3 && !r[2])) ? 2'h0 : i[1:0];
        pp = r[15:10];
        s0 = {5'h00, r[4], de} | (ovr ? 8'h40 : 8'h00);
        sp2 = {7'h00, i[0]};
        @(posedge mclk);
        {four_drives, swap_drives, index_address_field_mode, perp_load} <= {r[2:0], 1'b1};
        {perp_bits, specify_load, specify_byte1, specify_byte2} <= {pp, 1'b1, sp1, sp2};
        @(posedge mclk);
        {perp_load, specify_load} <= 2'b00;
        wb({1'b0, r[3], 6'h0D});
        wb({r[31:27], r[4], i[1:0]});
        wb({5'h00, i[2:0]});
        wb(8'h02);
        wb(r[31:24]);
        wb(~r[31:24]);
        @(negedge mclk);
        chk(write_gate, 1'b0, "gate before index");
        pulse(1'b1);
        wait_hi(1'b0);
        chk(write_gate, 1'b1, "gate after index");
        chk({logical_drive_select, head_select_output_n, double_density_select, iso_layout,
            group_layout}, {de, ~r[4], r[3], r[0], pp[1:0]}, "format setup");
        chk({gap3_len, fill_pattern, id_size}, {r[31:24], ~r[31:24], 5'h00, i[2:0]},
            "gap, fill and size");
        rb(2'h2, {6'h00, de}, 8'h03);
        rb(2'h3, {4'h0, r[4], 3'h0}, 8'h08);
        rb(2'h1, {~i[0], 1'b0, ~i[0], 5'h10}, 8'hF0);
        for (int k = 0; k < 2 && !ovr; k++)
        begin
            @(negedge mclk);
            chk(dma_req, i[0], "dma request");
            t = $urandom;
            wb(t[7:0]);
            wb(t[15:8]);
            wb(t[23:16]);
            wb({5'h00, i[2:0]});
            sq.push_back({t[7:0], t[15:8], t[23:16], 15'h0080 << i[2:0]});
            pulse(1'b0);
            repeat (3) @(posedge mclk);
        end
        pulse(!ovr);
        wait_hi(1'b1);
        chk({irq, write_gate}, 2'b10, "format end");
        rb(2'h0, s0, 8'hFF);
        @(negedge mclk);
        chk(irq, 1'b0, "irq after read");
        rb(2'h0, ovr ? 8'h10 : 8'h00, 8'hFF);
        for (int k = 0; k < 5; k++)
            rb(2'h0, 8'h00, 8'hFF);
        b7 = 8'h02;
    endtask : fmt

    // Read data stands only in the cycle after the strobe, so it is judged at the edge ending it.
    always @(posedge mclk)
    begin
        if (rd_q === 1'b1)
        begin
            e = rq.pop_front();
            chk(rdata & e[15:8], e[7:0], "read byte");
        end
        if (sector_valid === 1'b1)
        begin
            s = sq.pop_front();
            chk({id_track, id_head, id_sector, data_len}, s, "sector id");
        end
        rd_q <= rd;
    end

    // Watchdog: the whole sequence needs a few thousand cycles at most.
    initial
    begin
        repeat (20000) @(posedge mclk);
        miss("watchdog expired");
        end_sim();
    end

    // Main sequence.
    initial
    begin
        {soft_reset, wr, rd, specify_load, config_load, perp_load, lock_load} = 7'h00;
        {track_load, rw_done, index_address_field_mode, four_drives, swap_drives} = 5'h00;
        {lock_value, idx_req, sec_req, rd_q, lk} = 5'h00;
        {addr, track_drive, perp_bits, pp} = 16'h0000;
        {wdata, specify_byte1, specify_byte2, config_byte3, config_byte4} = 40'h0;
        {track_value, rw_end_sector, sp1, sp2, c4, b7} = 48'h0;
        c3 = 8'h20;
        trk = '{default: 8'h00};
        fail_count = 0;
        comparisons = 0;
        reset_n = 1'b0;
        void'($urandom(32'h74A30A74));
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        dump();
        $display("Test reset defaults done");
        for (int d = 0; d < 4; d++)
        begin
            @(posedge mclk);
            r = $urandom;
            {track_load, track_drive, track_value} <= {1'b1, d[1:0], r[7:0]};
            trk[d] = r[7:0];
        end
        @(posedge mclk);
        r = $urandom;
        {sp1, sp2, c3, c4} = r;
        {b7, pp, lk} = {r[7:0] ^ 8'h5A, r[13:8], 1'b1};
        track_load <= 1'b0;
        {specify_load, config_load, perp_load, lock_load, rw_done, lock_value} <= 6'h3F;
        {specify_byte1, specify_byte2, config_byte3, config_byte4} <= r;
        {perp_bits, rw_end_sector} <= {pp, b7};
        @(posedge mclk);
        {specify_load, config_load, perp_load, lock_load, rw_done} <= 5'h00;
        dump();
        srst();
        dump();
        @(posedge mclk);
        {lock_load, lock_value, lk} <= 3'b100;
        @(posedge mclk);
        lock_load <= 1'b0;
        srst();
        dump();
        $display("Test load and soft reset done");
        for (int i = 0; i < 8; i++)
            fmt(i, 1'b0);
        dump();
        $display("Test format done");
        fmt(5, 1'b1);
        $display("Test overrun done");
        wb(8'h3F);
        rb(2'h0, 8'h80, 8'hFF);
        @(negedge mclk);
        chk(irq, 1'b0, "invalid opcode irq");
        $display("Test invalid opcode done");
        repeat (3) @(posedge mclk);
        chk(rq.size() + sq.size(), 0, "queues drained");
        end_sim();
    end
endmodule : tb_top
